// ---- src/sab_dev_port.sv ----
`timescale 1ns/1ps
// Summary of operation
// R1: Add-bus enable and mode choose pin role.
// R2: Three independent channel copies of port logic.
// R3: Add-bus inputs sampled on clock falling edge.
// R4: Add clock 19.44 or 6.48 MHz; the host model drives it at 5 MHz.
// R5: Payload flag low during overhead bytes.
// R6: Phase marker high on C1/J0 and J1.
// R7: Parity even or odd, narrow or wide.
// R8: Parity setup from control byte 0x013B.
// R9: Send-message high: latch byte, build frame.
// R10: Send-message low: send continuous 0x7E flags.
// R11: Send-check appends frame check sequence trailer.
// R12: CRC-16 send-check lasts two demand periods.
// R13: CRC-32 send-check lasts four demand periods.
// R14: Line data sampled on selected clock edge.
// R15: Single rail: all data on positive input.
// R16: Dual rail: positive pulses on positive input.
// R17: Dual rail: negative pulses on negative input.
// R18: Alarm input high with each AIS byte.
// R19: Sampled alarm declares path AIS defect.
// R20: Parity mismatch sets sticky readable error flag.
module sab_dev_port #(
	parameter int HDLC_HALF = sab_pkg::HDLC_HALF_CYC
) (
	input  wire logic                           clk,
	input  wire logic                           sys_rst,
	sab_link_if.device                          link,
	input  wire logic [15:0]                    reg_addr,
	input  wire logic [7:0]                     reg_wdata,
	input  wire logic                           reg_wr,
	input  wire logic                           reg_rd,
	output logic [7:0]                          reg_rdata,
	output logic [sab_pkg::NUM_CH-1:0][7:0]     add_byte,
	output logic [sab_pkg::NUM_CH-1:0]          add_payload,
	output logic [sab_pkg::NUM_CH-1:0]          add_marker,
	output logic [sab_pkg::NUM_CH-1:0]          add_strobe,
	output logic [sab_pkg::NUM_CH-1:0]          ais_active,
	output logic [sab_pkg::NUM_CH-1:0][7:0]     hdlc_byte,
	output logic [sab_pkg::NUM_CH-1:0]          hdlc_fcs,
	output logic [sab_pkg::NUM_CH-1:0]          hdlc_strobe,
	output logic [sab_pkg::NUM_CH-1:0]          line_pos,
	output logic [sab_pkg::NUM_CH-1:0]          line_neg,
	output logic [sab_pkg::NUM_CH-1:0]          line_strobe
);

	localparam int NC = sab_pkg::NUM_CH;
	localparam logic [7:0] HALF_M1 = 8'(HDLC_HALF - 1);

	typedef enum logic [1:0] {
		HS_FLAG = 2'b00,
		HS_DATA = 2'b01,
		HS_FCS  = 2'b10
	} sab_hstate_type;

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	logic [7:0]    if_ctrl_r;
	logic [7:0]    cfg_r;
	logic [7:0]    rdata_r;
	logic [NC-1:0] perr_w;
	logic [NC-1:0] ais_w;
	logic [NC-1:0] perr_clr;
	logic [NC-1:0] ais_clr;

	// Control bytes; the parity setup steers every channel's checker.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			if_ctrl_r <= sab_pkg::IF_CTRL0_RESET;
			cfg_r <= sab_pkg::CHAN_CFG_RESET;
		end else if (reg_wr) begin
			if (reg_addr == sab_pkg::ADDR_IF_CTRL0) begin
				if_ctrl_r <= reg_wdata; // see R8
			end
			if (reg_addr == sab_pkg::ADDR_CHAN_CFG) begin
				cfg_r <= reg_wdata;
			end
		end
	end

	// Status bits clear by writing ones to them.
	assign perr_clr = (reg_wr && reg_addr == sab_pkg::ADDR_STATUS) ?
		reg_wdata[sab_pkg::ST_PERR_LSB +: NC] : '0;
	assign ais_clr = (reg_wr && reg_addr == sab_pkg::ADDR_STATUS) ?
		reg_wdata[sab_pkg::ST_AIS_LSB +: NC] : '0;

	// Read data stands in the cycle after the strobe; unmapped reads give zero.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_r <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				sab_pkg::ADDR_IF_CTRL0: rdata_r <= if_ctrl_r;
				sab_pkg::ADDR_CHAN_CFG: rdata_r <= cfg_r;
				sab_pkg::ADDR_STATUS: begin
					rdata_r <= 8'h00;
					rdata_r[sab_pkg::ST_PERR_LSB +: NC] <= perr_w; // see R20
					rdata_r[sab_pkg::ST_AIS_LSB +: NC] <= ais_w;
				end
				default: rdata_r <= 8'h00;
			endcase
		end else begin
			rdata_r <= 8'h00;
		end
	end

	assign reg_rdata = rdata_r;

	// ------------------------------------------------------------
	// Channels
	// ------------------------------------------------------------
	for (genvar g = 0; g < NC; g++) begin : g_ch // see R2
		sab_pkg::sab_role_type role;
		logic [12:0]      s1_r;
		logic [12:0]      s2_r;
		logic             ck_s;
		logic             pl_s;
		logic             mk_s;
		logic             dp_s;
		logic             al_s;
		logic [7:0]       d_s;
		logic             ck_d_r;
		logic             mk_d_r;
		logic             add_fall;
		logic             line_edge;
		logic             perr_set;
		logic             perr_r;
		logic             ais_r;
		logic [7:0]       abyte_r;
		logic             apl_r;
		logic             amk_r;
		logic             astb_r;
		logic             aais_r;
		logic             lpos_r;
		logic             lneg_r;
		logic             lstb_r;
		logic [7:0]       dcnt_r;
		logic             dclk_r;
		logic             hrise;
		sab_hstate_type   hst_r;
		logic [31:0]      crc_r;
		logic [31:0]      fcs_r;
		logic [7:0]       hbyte_r;
		logic             hfcs_r;
		logic             hstb_r;

		assign role = sab_pkg::role_of(cfg_r[sab_pkg::CFG_EN_LSB + g],
			cfg_r[sab_pkg::CFG_HDLC_LSB + g]); // see R1

		// Every pin comes from another clock, so all pass two flip-flops first.
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				s1_r <= 13'h0000;
				s2_r <= 13'h0000;
			end else begin
				s1_r <= {link.add_bus_clock[g], link.add_payload_flag[g],
					link.add_phase_marker[g], link.add_parity_in[g],
					link.add_alarm_in[g], link.add_data_bus[g]};
				s2_r <= s1_r;
			end
		end

		assign {ck_s, pl_s, mk_s, dp_s, al_s, d_s} = s2_r;

		// Previous synchronised clock levels for edge detection.
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				ck_d_r <= 1'b0;
				mk_d_r <= 1'b0;
			end else begin
				ck_d_r <= ck_s;
				mk_d_r <= mk_s;
			end
		end

		assign add_fall = (role == sab_pkg::ROLE_ADD) && ck_d_r && !ck_s; // see R3
		assign line_edge = (role == sab_pkg::ROLE_LINE) &&
			(cfg_r[sab_pkg::CFG_EDGE_BIT] ? (mk_s && !mk_d_r) : (!mk_s && mk_d_r)); // see R14
		assign perr_set = add_fall && (dp_s != sab_pkg::calc_parity(d_s, pl_s, mk_s,
			if_ctrl_r[sab_pkg::IFC_WIDE_BIT], if_ctrl_r[sab_pkg::IFC_ODD_BIT])); // see R7

		// Add-bus capture; the byte and its flags go out together with a strobe.
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				abyte_r <= 8'h00;
				apl_r <= 1'b0;
				amk_r <= 1'b0;
				astb_r <= 1'b0;
				aais_r <= 1'b0;
			end else begin
				astb_r <= add_fall;
				if (add_fall) begin
					abyte_r <= d_s; // see R3
					apl_r <= pl_s;
					amk_r <= mk_s;
					aais_r <= al_s; // see R19
				end else if (role != sab_pkg::ROLE_ADD) begin
					aais_r <= 1'b0;
				end
			end
		end

		// Sticky flags; a new event in the clearing cycle wins.
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				perr_r <= 1'b0;
				ais_r <= 1'b0;
			end else begin
				if (perr_set) begin
					perr_r <= 1'b1; // see R20
				end else if (perr_clr[g]) begin
					perr_r <= 1'b0;
				end
				if (add_fall && al_s) begin
					ais_r <= 1'b1; // see R19
				end else if (ais_clr[g]) begin
					ais_r <= 1'b0;
				end
			end
		end

		// Line receive; the negative rail is only meaningful in dual-rail mode.
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				lpos_r <= 1'b0;
				lneg_r <= 1'b0;
				lstb_r <= 1'b0;
			end else begin
				lstb_r <= line_edge;
				if (line_edge) begin
					lpos_r <= dp_s; // see R15
					lneg_r <= cfg_r[sab_pkg::CFG_DUAL_BIT] & al_s; // see R17
				end
			end
		end

		// Demand clock divider; it runs only while the channel is in HDLC mode.
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				dcnt_r <= 8'h00;
				dclk_r <= 1'b0;
			end else if (role != sab_pkg::ROLE_HDLC) begin
				dcnt_r <= 8'h00;
				dclk_r <= 1'b0;
			end else if (dcnt_r == HALF_M1) begin
				dcnt_r <= 8'h00;
				dclk_r <= !dclk_r;
			end else begin
				dcnt_r <= dcnt_r + 8'h01;
			end
		end

		// The byte is taken as our own demand clock rises; the host moved it half a
		// period earlier, which leaves room for the synchroniser delay.
		assign hrise = (role == sab_pkg::ROLE_HDLC) && (dcnt_r == HALF_M1) && !dclk_r;

		// Frame builder: flags, data with running CRC, then the inverted CRC.
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				hst_r <= HS_FLAG;
				crc_r <= sab_pkg::CRC_INIT;
				fcs_r <= 32'h00000000;
				hbyte_r <= 8'h00;
				hfcs_r <= 1'b0;
				hstb_r <= 1'b0;
			end else begin
				hstb_r <= hrise;
				if (hrise) begin
					if (ck_s) begin
						hfcs_r <= 1'b1; // see R11
						if (hst_r != HS_FCS) begin
							hst_r <= HS_FCS;
							hbyte_r <= ~crc_r[7:0];
							fcs_r <= (~crc_r) >> 8;
						end else begin
							hbyte_r <= fcs_r[7:0]; // see R12
							fcs_r <= fcs_r >> 8; // see R13
						end
					end else if (pl_s) begin
						hst_r <= HS_DATA;
						hfcs_r <= 1'b0;
						hbyte_r <= d_s; // see R9
						crc_r <= sab_pkg::crc_byte((hst_r == HS_DATA) ? crc_r : sab_pkg::CRC_INIT,
							d_s, if_ctrl_r[sab_pkg::IFC_CRC32_BIT]);
					end else begin
						hst_r <= HS_FLAG;
						hfcs_r <= 1'b0;
						hbyte_r <= sab_pkg::HDLC_FLAG; // see R10
						crc_r <= sab_pkg::CRC_INIT;
					end
				end
			end
		end

		assign perr_w[g] = perr_r;
		assign ais_w[g] = ais_r;
		assign add_byte[g] = abyte_r;
		assign add_payload[g] = apl_r;
		assign add_marker[g] = amk_r;
		assign add_strobe[g] = astb_r;
		assign ais_active[g] = aais_r;
		assign line_pos[g] = lpos_r;
		assign line_neg[g] = lneg_r;
		assign line_strobe[g] = lstb_r;
		assign hdlc_byte[g] = hbyte_r;
		assign hdlc_fcs[g] = hfcs_r;
		assign hdlc_strobe[g] = hstb_r;
		assign link.hdlc_demand_clock[g] = dclk_r;
	end

endmodule

// ---- src/sab_pkg.sv ----
package sab_pkg;

	// ------------------------------------------------------------
	// Sizes and register map
	// ------------------------------------------------------------
	localparam int NUM_CH = 3;
	localparam int DATA_W = 8;
	localparam logic [15:0] ADDR_IF_CTRL0 = 16'h013B;
	localparam logic [15:0] ADDR_CHAN_CFG = 16'h0140;
	localparam logic [15:0] ADDR_STATUS = 16'h0141;
	localparam logic [7:0] IF_CTRL0_RESET = 8'h00;
	localparam logic [7:0] CHAN_CFG_RESET = 8'h00;
	// Interface control byte: parity sense, parity coverage, CRC width.
	localparam int IFC_ODD_BIT = 0;
	localparam int IFC_WIDE_BIT = 1;
	localparam int IFC_CRC32_BIT = 2;
	// Channel configuration byte: add-bus enables, HDLC modes, line edge, dual rail.
	localparam int CFG_EN_LSB = 0;
	localparam int CFG_HDLC_LSB = 3;
	localparam int CFG_EDGE_BIT = 6;
	localparam int CFG_DUAL_BIT = 7;
	// Status byte: sticky parity errors, sticky path AIS.
	localparam int ST_PERR_LSB = 0;
	localparam int ST_AIS_LSB = 3;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int LINK_CLK_PERIOD_NS = 200;
	localparam int HDLC_DEMAND_PERIOD_NS = 400;
	localparam int LINK_HALF_CYC = LINK_CLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int HDLC_HALF_CYC = HDLC_DEMAND_PERIOD_NS / (2 * CLK_PERIOD_NS);

	// ------------------------------------------------------------
	// HDLC constants
	// ------------------------------------------------------------
	localparam logic [7:0] HDLC_FLAG = 8'h7E;
	localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
	localparam logic [31:0] CRC16_MASK = 32'h0000FFFF;
	localparam logic [31:0] CRC16_POLY = 32'h00008408;
	localparam logic [31:0] CRC32_POLY = 32'hEDB88320;
	localparam logic [2:0] FCS16_PERIODS = 3'h2;
	localparam logic [2:0] FCS32_PERIODS = 3'h4;

	typedef enum logic [1:0] {
		ROLE_ADD  = 2'b00,
		ROLE_HDLC = 2'b01,
		ROLE_LINE = 2'b10
	} sab_role_type;

	// Pin role of one channel from its add-bus enable and HDLC mode.
	function automatic sab_role_type role_of(input logic add_en, input logic hdlc);
		return add_en ? ROLE_ADD : (hdlc ? ROLE_HDLC : ROLE_LINE);
	endfunction

	// Parity bit for the add bus, even or odd, narrow or wide coverage.
	function automatic logic calc_parity(input logic [7:0] d, input logic pl, input logic mk,
		input logic wide, input logic odd);
		return (^d) ^ (wide & (pl ^ mk)) ^ odd;
	endfunction

	// One byte of reflected CRC, least significant bit first, 16 or 32 bits.
	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d,
		input logic wide32);
		logic [31:0] r;
		logic [31:0] poly;
		r = wide32 ? c : (c & CRC16_MASK);
		poly = wide32 ? CRC32_POLY : CRC16_POLY;
		for (int i = 0; i < DATA_W; i++) begin
			if (r[0] ^ d[i]) begin
				r = (r >> 1) ^ poly;
			end else begin
				r = r >> 1;
			end
		end
		return r;
	endfunction

endpackage

// ---- src/sab_link_if.sv ----
`timescale 1ns/1ps
// Shared pins of all channels; each pin's meaning depends on the channel role.
interface sab_link_if;
	logic [sab_pkg::NUM_CH-1:0]           add_bus_clock;     // Also HDLC send-check.
	logic [sab_pkg::NUM_CH-1:0]           add_payload_flag;  // Also HDLC send-message.
	logic [sab_pkg::NUM_CH-1:0]           add_phase_marker;  // Also line receive clock.
	logic [sab_pkg::NUM_CH-1:0]           add_parity_in;     // Also line positive data.
	logic [sab_pkg::NUM_CH-1:0]           add_alarm_in;      // Also line negative data.
	logic [sab_pkg::NUM_CH-1:0][7:0]      add_data_bus;      // Also HDLC transmit byte.
	logic [sab_pkg::NUM_CH-1:0]           hdlc_demand_clock;

	modport device (
		input  add_bus_clock,
		input  add_payload_flag,
		input  add_phase_marker,
		input  add_parity_in,
		input  add_alarm_in,
		input  add_data_bus,
		output hdlc_demand_clock
	);

	modport host (
		output add_bus_clock,
		output add_payload_flag,
		output add_phase_marker,
		output add_parity_in,
		output add_alarm_in,
		output add_data_bus,
		input  hdlc_demand_clock
	);
endinterface

// ---- src/sab_host_port.sv ----
`timescale 1ns/1ps
// Far party: drives the shared pins of each channel in the role that the
// channel configuration selects.
module sab_host_port #(
	parameter int LINK_HALF = sab_pkg::LINK_HALF_CYC
) (
	input  wire logic                           clk,
	input  wire logic                           sys_rst,
	sab_link_if.host                            link,
	input  wire logic [sab_pkg::NUM_CH-1:0]     role_add_en,
	input  wire logic [sab_pkg::NUM_CH-1:0]     role_hdlc,
	input  wire logic                           parity_odd,
	input  wire logic                           parity_wide,
	input  wire logic                           crc32_mode,
	input  wire logic                           line_rise_edge,
	input  wire logic                           dual_rail,
	input  wire logic [sab_pkg::NUM_CH-1:0][7:0] src_byte,
	input  wire logic [sab_pkg::NUM_CH-1:0]     src_payload,
	input  wire logic [sab_pkg::NUM_CH-1:0]     src_marker,
	input  wire logic [sab_pkg::NUM_CH-1:0]     src_alarm,
	input  wire logic [sab_pkg::NUM_CH-1:0]     src_msg,
	input  wire logic [sab_pkg::NUM_CH-1:0]     src_pos,
	input  wire logic [sab_pkg::NUM_CH-1:0]     src_neg,
	input  wire logic [sab_pkg::NUM_CH-1:0]     fcs_req,
	output logic [sab_pkg::NUM_CH-1:0]          src_take,
	output logic [sab_pkg::NUM_CH-1:0]          fcs_busy
);

	localparam int NC = sab_pkg::NUM_CH;
	localparam logic [7:0] HALF_M1 = 8'(LINK_HALF - 1);

	for (genvar g = 0; g < NC; g++) begin : g_ch
		sab_pkg::sab_role_type role;
		logic [7:0]  cnt_r;
		logic        lclk_r;
		logic        rise_nxt;
		logic        fall_nxt;
		logic        add_go;
		logic        line_go;
		logic        ds1_r;
		logic        ds2_r;
		logic        dd_r;
		logic        dfall;
		logic [7:0]  dat_r;
		logic        pl_r;
		logic        mk_r;
		logic        dp_r;
		logic        al_r;
		logic        msg_r;
		logic        chk_r;
		logic        pend_r;
		logic [2:0]  left_r;
		logic        take_r;

		assign role = sab_pkg::role_of(role_add_en[g], role_hdlc[g]);

		// Link clock divider for the add bus and line roles.
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				cnt_r <= 8'h00;
				lclk_r <= 1'b0;
			end else if (role == sab_pkg::ROLE_HDLC) begin
				cnt_r <= 8'h00;
				lclk_r <= 1'b0;
			end else if (cnt_r == HALF_M1) begin
				cnt_r <= 8'h00;
				lclk_r <= !lclk_r;
			end else begin
				cnt_r <= cnt_r + 8'h01;
			end
		end

		assign rise_nxt = (cnt_r == HALF_M1) && !lclk_r;
		assign fall_nxt = (cnt_r == HALF_M1) && lclk_r;
		// Data moves on the rising edge so it is steady at the sampling fall.
		assign add_go = (role == sab_pkg::ROLE_ADD) && rise_nxt; // see R3
		assign line_go = (role == sab_pkg::ROLE_LINE) && (line_rise_edge ? fall_nxt : rise_nxt);

		// The demand clock comes from the device, so it is synchronised first.
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				ds1_r <= 1'b0;
				ds2_r <= 1'b0;
				dd_r <= 1'b0;
			end else begin
				ds1_r <= link.hdlc_demand_clock[g];
				ds2_r <= ds1_r;
				dd_r <= ds2_r;
			end
		end

		assign dfall = (role == sab_pkg::ROLE_HDLC) && dd_r && !ds2_r;

		// Pin drivers for all three roles; the user stream follows R5, R6 and R18.
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				dat_r <= 8'h00;
				pl_r <= 1'b0;
				mk_r <= 1'b0;
				dp_r <= 1'b0;
				al_r <= 1'b0;
				msg_r <= 1'b0;
				take_r <= 1'b0;
			end else begin
				take_r <= 1'b0;
				if (add_go) begin
					dat_r <= src_byte[g];
					pl_r <= src_payload[g]; // see R5
					mk_r <= src_marker[g]; // see R6
					al_r <= src_alarm[g]; // see R18
					dp_r <= sab_pkg::calc_parity(src_byte[g], src_payload[g], src_marker[g],
						parity_wide, parity_odd); // see R7
					take_r <= 1'b1;
				end else if (line_go) begin
					dp_r <= src_pos[g]; // see R15, see R16
					al_r <= dual_rail & src_neg[g]; // see R17
					take_r <= 1'b1;
				end else if (dfall) begin
					msg_r <= src_msg[g] && !(pend_r || chk_r);
					dat_r <= src_byte[g];
					take_r <= src_msg[g] && !(pend_r || chk_r);
				end
			end
		end

		// Send-check is held for a whole number of demand periods.
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				chk_r <= 1'b0;
				pend_r <= 1'b0;
				left_r <= 3'h0;
			end else begin
				if (fcs_req[g]) begin
					pend_r <= 1'b1;
				end else if (dfall && !chk_r) begin
					pend_r <= 1'b0;
				end
				if (dfall) begin
					if (chk_r) begin
						left_r <= left_r - 3'h1;
						chk_r <= (left_r != 3'h1);
					end else if (pend_r) begin
						chk_r <= 1'b1;
						left_r <= crc32_mode ? sab_pkg::FCS32_PERIODS :
							sab_pkg::FCS16_PERIODS; // see R12, see R13
					end
				end
			end
		end

		assign link.add_bus_clock[g] = (role == sab_pkg::ROLE_ADD) ? lclk_r :
			((role == sab_pkg::ROLE_HDLC) ? chk_r : 1'b0); // see R4
		assign link.add_payload_flag[g] = (role == sab_pkg::ROLE_ADD) ? pl_r :
			((role == sab_pkg::ROLE_HDLC) ? msg_r : 1'b0);
		assign link.add_phase_marker[g] = (role == sab_pkg::ROLE_ADD) ? mk_r :
			((role == sab_pkg::ROLE_LINE) ? lclk_r : 1'b0);
		assign link.add_parity_in[g] = dp_r;
		assign link.add_alarm_in[g] = al_r;
		assign link.add_data_bus[g] = dat_r;
		assign src_take[g] = take_r;
		assign fcs_busy[g] = chk_r || pend_r;
	end

endmodule

// ---- sim/sab_link_props.sv ----
`timescale 1ns/1ps
// ------
// Wire checks on channel 0 of the shared pins.
// ------
module sab_link_props (
	input wire logic            clk,
	input wire logic            sys_rst,
	input wire logic [2:0]      add_bus_clock,
	input wire logic [2:0]      add_payload_flag,
	input wire logic [2:0]      add_phase_marker,
	input wire logic [2:0]      add_parity_in,
	input wire logic [2:0]      add_alarm_in,
	input wire logic [2:0][7:0] add_data_bus,
	input wire logic [2:0]      hdlc_demand_clock
);
	logic       hdlc_r;
	logic [6:0] high_r;

	// A running demand clock is the only sign of the HDLC role on the wire.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hdlc_r <= 1'b0;
		end else if (hdlc_demand_clock[0]) begin
			hdlc_r <= 1'b1;
		end
	end

	// Length of each high spell; it wraps, so only short spells are judged.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			high_r <= 7'h00;
		end else begin
			high_r <= add_bus_clock[0] ? high_r + 7'h01 : 7'h00;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	sequence dem_high;
		hdlc_demand_clock[0] [*8];
	endsequence
	sequence dem_low;
		(!hdlc_demand_clock[0]) [*8];
	endsequence

	dem_period_a: assert property ($rose(hdlc_demand_clock[0]) |->
		dem_high ##1 dem_low ##1 hdlc_demand_clock[0])
		else $error("Demand clock period is wrong.");
	clk_half_a: assert property (!hdlc_r && $rose(add_bus_clock[0]) |->
		add_bus_clock[0] [*4] ##1 !add_bus_clock[0])
		else $error("Add clock half period is wrong.");
	fcs_len_a: assert property (hdlc_r && $fell(add_bus_clock[0]) |->
		high_r == 7'h20 || high_r == 7'h40)
		else $error("Send-check length is wrong.");
	msg_off_a: assert property (hdlc_r && add_bus_clock[0] |->
		!add_payload_flag[0])
		else $error("Send-message high during send-check.");
	hdlc_data_a: assert property (hdlc_r && $changed(add_data_bus[0]) |->
		!hdlc_demand_clock[0] && !$past(hdlc_demand_clock[0]))
		else $error("HDLC byte changed near demand edge.");
	add_data_a: assert property (!hdlc_r && $changed(add_data_bus[0]) |->
		$rose(add_bus_clock[0]))
		else $error("Add byte changed off the clock rise.");
	flag_edge_a: assert property (!hdlc_r && $changed(add_payload_flag[0]) |->
		$rose(add_bus_clock[0]))
		else $error("Payload flag changed off the clock rise.");
	rail_edge_a: assert property (
		!hdlc_r && $changed({add_parity_in[0], add_alarm_in[0]}) |->
		$rose(add_bus_clock[0]) || $changed(add_phase_marker[0]))
		else $error("Parity or rail changed off a clock edge.");
endmodule

// ---- sim/sab_tb.sv ----
`timescale 1ns/1ps
module sab_tb;
	// ------
	// Signals
	// ------
	logic            clk = 1'b0;
	logic            sys_rst = 1'b1;
	logic [15:0]     reg_addr;
	logic [7:0]      reg_wdata, reg_rdata;
	logic            reg_wr, reg_rd, parity_odd, parity_wide, crc32_mode, line_rise_edge, dual_rail;
	logic [2:0]      role_add_en, role_hdlc, src_payload, src_marker, src_alarm, src_msg;
	logic [2:0]      src_pos, src_neg, fcs_req, src_take, fcs_busy, add_payload, add_marker;
	logic [2:0]      add_strobe, ais_active, hdlc_fcs, hdlc_strobe, line_pos, line_neg, line_strobe;
	logic [2:0][7:0] src_byte, add_byte, hdlc_byte;
	logic [31:0]     fcs;
	int              mismatches = 0;
	int              n_checks = 0;
	int              cyc = 0;

	sab_link_if lnk ();
	sab_dev_port u_sab_dev_port (.clk, .sys_rst, .link(lnk), .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .add_byte, .add_payload, .add_marker, .add_strobe, .ais_active,
		.hdlc_byte, .hdlc_fcs, .hdlc_strobe, .line_pos, .line_neg, .line_strobe);
	sab_host_port u_sab_host_port (.clk, .sys_rst, .link(lnk), .role_add_en, .role_hdlc,
		.parity_odd, .parity_wide, .crc32_mode, .line_rise_edge, .dual_rail, .src_byte,
		.src_payload, .src_marker, .src_alarm, .src_msg, .src_pos, .src_neg, .fcs_req,
		.src_take, .fcs_busy);
	sab_link_props u_sab_link_props (.clk, .sys_rst, .add_bus_clock(lnk.add_bus_clock),
		.add_payload_flag(lnk.add_payload_flag), .add_phase_marker(lnk.add_phase_marker),
		.add_parity_in(lnk.add_parity_in), .add_alarm_in(lnk.add_alarm_in),
		.add_data_bus(lnk.add_data_bus), .hdlc_demand_clock(lnk.hdlc_demand_clock));

	// Free-running 40 MHz clock.
	always #12.5 clk = ~clk;

	// ------
	// Tasks
	// ------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d.", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic restart();
		sys_rst <= 1'b1;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
	endtask

	task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, exp);
	endtask

	// Waits for a channel 0 pulse: 0 launch, 1 add, 2 HDLC, 3 line; sampled 1 ns late.
	task automatic wait_on(input int k);
		int n;
		logic [3:0] s;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			s = {line_strobe[0], hdlc_strobe[0], add_strobe[0], src_take[0]};
			n++;
		end while (s[k] !== 1'b1 && n < 300);
		if (n >= 300) mismatches++;
	endtask

	// Two launches make sure the new values are on the wire, then the result lands.
	task automatic send(input int k);
		wait_on(0);
		wait_on(0);
		wait_on(k);
		#50;
	endtask

	// Reflected CRC over one byte, complemented; kept apart from the design's own code.
	function automatic logic [31:0] fcs_of(input logic [7:0] d, input logic w32);
		logic [31:0] r;
		logic [31:0] p;
		r = w32 ? 32'hFFFFFFFF : 32'h0000FFFF;
		p = w32 ? sab_pkg::CRC32_POLY : sab_pkg::CRC16_POLY;
		for (int i = 0; i < 8; i++) begin
			r = (r >> 1) ^ ((r[0] ^ d[i]) ? p : 32'h00000000);
		end
		return ~r;
	endfunction

	// A hang counts as a mismatch and ends the run.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	// ------
	// Sequence
	// ------
	initial begin
		{reg_addr, reg_wdata, reg_wr, reg_rd, parity_odd, parity_wide, crc32_mode} = '0;
		{line_rise_edge, dual_rail, role_add_en, role_hdlc, src_payload, src_marker} = '0;
		{src_alarm, src_msg, src_pos, src_neg, fcs_req, src_byte} = '0;
		restart();
		reg_read(sab_pkg::ADDR_IF_CTRL0, sab_pkg::IF_CTRL0_RESET);
		reg_read(sab_pkg::ADDR_CHAN_CFG, sab_pkg::CHAN_CFG_RESET);
		reg_write(16'h0000, 8'hFF);
		reg_read(16'h0000, 8'h00);
		reg_write(sab_pkg::ADDR_IF_CTRL0, 8'h07);
		reg_read(sab_pkg::ADDR_IF_CTRL0, 8'h07);
		// Add bus: distinct bytes per channel, then a parity clash and an alarm.
		role_add_en <= 3'h7;
		parity_wide <= 1'b1;
		restart();
		reg_write(sab_pkg::ADDR_CHAN_CFG, 8'h07);
		reg_write(sab_pkg::ADDR_IF_CTRL0, 8'h02);
		for (int i = 0; i < 4; i++) begin
			for (int c = 0; c < 3; c++) src_byte[c] <= 8'hA5 ^ {i[3:0], 2'h0, c[1:0]};
			src_payload <= {3{i != 0}};
			src_marker <= {3{i == 2}};
			send(1);
			for (int c = 0; c < 3; c++) check({add_marker[c], add_payload[c], add_byte[c]},
				{i == 2, i != 0, 8'hA5 ^ {i[3:0], 2'h0, c[1:0]}});
		end
		reg_read(sab_pkg::ADDR_STATUS, 8'h00);
		parity_odd <= 1'b1;
		src_alarm <= 3'h2;
		send(1);
		check(ais_active, 3'h2);
		reg_read(sab_pkg::ADDR_STATUS, 8'h17);
		parity_odd <= 1'b0;
		src_alarm <= 3'h0;
		send(1);
		reg_write(sab_pkg::ADDR_STATUS, 8'hFF);
		reg_read(sab_pkg::ADDR_STATUS, 8'h00);
		// HDLC: flags, one data byte and its trailer, for both check widths.
		role_add_en <= 3'h0;
		role_hdlc <= 3'h7;
		restart();
		reg_write(sab_pkg::ADDR_CHAN_CFG, 8'h38);
		for (int w = 0; w < 2; w++) begin
			crc32_mode <= w[0];
			reg_write(sab_pkg::ADDR_IF_CTRL0, {5'h00, w[0], 2'h0});
			wait_on(2);
			wait_on(2);
			check({hdlc_fcs[0], hdlc_byte[0]}, 9'h07E);
			src_msg <= 3'h7;
			src_byte[0] <= 8'h31 + w[7:0];
			wait_on(0);
			src_msg <= 3'h0;
			fcs_req <= 3'h7;
			@(posedge clk);
			fcs_req <= 3'h0;
			wait_on(2);
			check({hdlc_fcs[0], hdlc_byte[0]}, {1'b0, 8'h31 + w[7:0]});
			check(fcs_busy, 3'h7);
			fcs = fcs_of(8'h31 + w[7:0], w[0]);
			for (int j = 0; j < 2 + 2 * w; j++) begin
				wait_on(2);
				check({hdlc_fcs[0], hdlc_byte[0]}, {1'b1, fcs[8 * j +: 8]});
			end
			wait_on(2);
			check({hdlc_fcs[0], hdlc_byte[0]}, 9'h07E);
			check(fcs_busy, 3'h0);
		end
		// Line receive: falling edge single rail, then rising edge dual rail.
		role_hdlc <= 3'h0;
		src_byte <= '0;
		for (int m = 0; m < 2; m++) begin
			line_rise_edge <= m[0];
			dual_rail <= m[0];
			restart();
			reg_write(sab_pkg::ADDR_CHAN_CFG, {m[0], m[0], 6'h00});
			for (int i = 0; i < 2; i++) begin
				src_pos <= {3{i[0]}};
				src_neg <= {3{!i[0]}};
				send(3);
				check({line_pos[0], line_neg[0]}, {i[0], !i[0] && m[0]});
			end
		end
		tally_and_finish();
	end
endmodule
